// ===== rtl/psec_pkg.sv
package psec_pkg;
	// power states as carried by the power-state command
	localparam logic [7:0] POWER_STATE_ZERO = 8'h00;
	localparam logic [7:0] POWER_STATE_ONE  = 8'h01;

	// register byte offsets
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] THR_OFS    = 4'h4;
	localparam logic [3:0] GDTHR_OFS  = 4'h8;
	localparam logic [3:0] STATUS_OFS = 4'hc;

	// control register fields
	localparam int CTRL_SHED_EN_BIT  = 0;
	localparam int CTRL_GD_HIGH_BIT  = 1;
	localparam int CTRL_STUFFED_LSB  = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0031;

	// threshold register: one_two in [11:0], two_three in [27:16]
	localparam int THR_12_LSB = 0;
	localparam int THR_23_LSB = 16;
	localparam logic [11:0] THR_12_RST   = 12'h100;
	localparam logic [11:0] THR_23_RST   = 12'h200;
	localparam logic [11:0] GDTHR_RST    = 12'h0c0;

	// current-limit full scale 2.5 V on a 12-bit code
	localparam int          VOCP_MV      = 2500;
	localparam logic [11:0] VOCP_CODE    = 12'hfff;

	// timing
	localparam int CLK_MHZ          = 200;
	localparam int MIN_DE_FREQ_KHZ  = 30;
	localparam int DE_MAX_WAIT_CYC  = (CLK_MHZ * 1000) / MIN_DE_FREQ_KHZ;
	localparam int REARM_DELAY_US   = 10;
	localparam int REARM_DELAY_CYC  = REARM_DELAY_US * CLK_MHZ;
endpackage

// ===== rtl/psec_ctrl.sv
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
module psec_ctrl (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        i_power_state_command,
	input  wire logic [7:0]  i_power_state,
	input  wire logic        i_voltage_set_command,
	input  wire logic        i_fast_transient,
	input  wire logic        i_rail_good,
	input  wire logic        i_shed_strap,
	input  wire logic [11:0] i_current_monitor,
	input  wire logic [11:0] i_current_limit_voltage,
	input  wire logic        i_cycle_start,
	input  wire logic [15:0] i_on_time,
	input  wire logic [15:0] i_off_time,
	input  wire logic        i_zero_cross_detect,
	input  wire logic        i_thermal_comp_grounded,
	output logic [1:0]       o_phase_count,
	output logic             o_variable_freq_diode_emulation,
	output logic             o_gate_drive_supply_select,
	output logic             o_thermal_comp_enable,
	output logic             o_sw_high,
	output logic             o_sw_low,
	output logic             o_sw_oe
);
	import psec_pkg::*;

	typedef enum logic [1:0] {PSEC_IDLE, PSEC_HIGH, PSEC_LOW, PSEC_HIZ} psec_de_t;

	logic [31:0] ctrl_q;
	logic [11:0] thr12_q, thr23_q, gdthr_q;
	logic [7:0]  ps_q;
	logic        ack_q;
	logic        armed_q;
	logic [15:0] rearm_cnt_q;
	logic [1:0]  phase_q;
	psec_de_t    de_state_q;
	logic [15:0] de_cnt_q;

	// bus decode
	wire         req      = (avs_read | avs_write) & ~ack_q;
	wire         wr_ctrl  = avs_write & ack_q & (avs_address == CTRL_OFS);
	wire         wr_thr   = avs_write & ack_q & (avs_address == THR_OFS);
	wire         wr_gdthr = avs_write & ack_q & (avs_address == GDTHR_OFS);
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

	wire         ps_zero   = (ps_q == POWER_STATE_ZERO);
	wire         shed_cfg  = ctrl_q[CTRL_SHED_EN_BIT] & i_shed_strap;
	wire         shed_on   = ps_zero ? shed_cfg : 1'b1;
	wire [1:0]   stuffed   = ctrl_q[CTRL_STUFFED_LSB +: 2];
	wire [1:0]   max_ph    = ps_zero ? stuffed : ((stuffed > 2'd2) ? 2'd2 : stuffed);

	// phase count wanted by the monitor against the two thresholds
	wire [1:0]   mon_ph = (i_current_monitor >= thr23_q) ? 2'd3 :
	                      (i_current_monitor >= thr12_q) ? 2'd2 : 2'd1;
	// step index of current limit: each step is 2.5 V / (2N) wide
	// 16 bits: full-scale code times three phases times two needs 15
	wire [15:0]  step_sc = 16'(i_current_limit_voltage) * 16'(stuffed) * 16'h2;
	wire [1:0]   lim_ph   = (step_sc >= 16'(VOCP_CODE) * 16'h2) ? 2'd3 :
	                        (step_sc >= 16'(VOCP_CODE)) ? 2'd2 : 2'd1;
	wire [1:0]   want_ph0 = (lim_ph > mon_ph) ? lim_ph : mon_ph;
	wire [1:0]   want_cap = (want_ph0 > max_ph) ? max_ph : want_ph0;
	wire         shedding = shed_on & armed_q & i_rail_good;
	wire [1:0]   target   = shedding ? want_cap : max_ph;

	wire         single   = (phase_q == 2'd1);
	wire         gd_low_mon = (i_current_monitor < gdthr_q);

	// registers
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ack_q   <= 1'b0;
			ctrl_q  <= CTRL_RST;
			thr12_q <= THR_12_RST;
			thr23_q <= THR_23_RST;
			gdthr_q <= GDTHR_RST;
		end else begin
			ack_q <= req;
			if (wr_ctrl)
				ctrl_q <= avs_writedata & 32'h0000_0033;
			if (wr_thr) begin
				thr12_q <= avs_writedata[THR_12_LSB +: 12];
				thr23_q <= avs_writedata[THR_23_LSB +: 12];
			end
			if (wr_gdthr)
				gdthr_q <= avs_writedata[11:0];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn)
			avs_readdata <= 32'h0;
		else if (avs_read & ~ack_q) begin
			case (avs_address)
				CTRL_OFS:   avs_readdata <= ctrl_q;
				THR_OFS:    avs_readdata <= {4'h0, thr23_q, 4'h0, thr12_q};
				GDTHR_OFS:  avs_readdata <= {20'h0, gdthr_q};
				STATUS_OFS: avs_readdata <= {16'h0, ps_q, 1'b0, armed_q, phase_q,
				                             o_sw_oe, o_gate_drive_supply_select,
				                             o_variable_freq_diode_emulation,
				                             o_thermal_comp_enable};
				default:    avs_readdata <= 32'h0;
			endcase
		end
	end

	// power state latched on each command
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn)
			ps_q <= POWER_STATE_ZERO;
		else if (i_power_state_command)
			ps_q <= i_power_state;
	end

	// shedding reset and re-arm delay
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			armed_q     <= 1'b0;
			rearm_cnt_q <= 16'h0;
		end else if (i_voltage_set_command | i_fast_transient | ~i_rail_good) begin
			armed_q     <= 1'b0;
			rearm_cnt_q <= 16'h0;
		end else if (!armed_q) begin
			if (rearm_cnt_q == 16'(REARM_DELAY_CYC - 1))
				armed_q <= 1'b1;
			else
				rearm_cnt_q <= rearm_cnt_q + 16'h1;
		end
	end

	// phase count moves only at a cycle boundary
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn)
			phase_q <= 2'd3;
		else if (i_cycle_start)
			phase_q <= target;
	end

	// diode emulation pulse sequencer
	wire de_allow = single & (ps_zero ? shed_on : 1'b1) & i_zero_cross_detect;
	// >= so a long on plus off time still ends the wait at once
	wire de_timeout = (de_cnt_q >= 16'(DE_MAX_WAIT_CYC - 1));

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			de_state_q <= PSEC_IDLE;
			de_cnt_q   <= 16'h0;
		end else begin
			case (de_state_q)
				PSEC_IDLE: begin
					de_cnt_q <= 16'h0;
					if (i_cycle_start)
						de_state_q <= PSEC_HIGH;
				end
				PSEC_HIGH: begin
					de_cnt_q <= de_cnt_q + 16'h1;
					if (de_cnt_q + 16'h1 >= i_on_time)
						de_state_q <= PSEC_LOW;
				end
				PSEC_LOW: begin
					de_cnt_q <= de_cnt_q + 16'h1;
					if (de_cnt_q + 16'h1 >= i_on_time + i_off_time)
						de_state_q <= de_allow ? PSEC_HIZ : PSEC_IDLE;
				end
				PSEC_HIZ: begin
					de_cnt_q <= de_cnt_q + 16'h1;
					if (i_cycle_start | de_timeout) begin
						de_state_q <= PSEC_HIGH;
						de_cnt_q   <= 16'h0;
					end
				end
				default: de_state_q <= PSEC_IDLE;
			endcase
		end
	end

	assign o_sw_high = (de_state_q == PSEC_HIGH);
	assign o_sw_low  = (de_state_q == PSEC_LOW) | (de_state_q == PSEC_IDLE);
	assign o_sw_oe   = (de_state_q != PSEC_HIZ);
	assign o_phase_count = phase_q;
	assign o_variable_freq_diode_emulation = (de_state_q == PSEC_HIZ);
	// 1 = high drive supply, 0 = five volt supply
	assign o_gate_drive_supply_select = ps_zero & ctrl_q[CTRL_GD_HIGH_BIT] & ~gd_low_mon;
	assign o_thermal_comp_enable = ~i_thermal_comp_grounded;

	ps_latch_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		i_power_state_command |=> ps_q == $past(i_power_state))
		else $error("power state not latched");

	ps1_shed_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(!ps_zero && i_cycle_start) |=> phase_q <= 2'h2)
		else $error("too many phases in state one");

	gd_low_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		!ps_zero |-> !o_gate_drive_supply_select)
		else $error("gate drive not five volt");

	soft_all_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(!i_rail_good && i_cycle_start) |=> phase_q == $past(max_ph))
		else $error("not all phases before rail good");

	shed_rst_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		i_voltage_set_command |=> !armed_q)
		else $error("shedding not reset");

	step_up_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(shedding && i_cycle_start && lim_ph <= max_ph) |=> phase_q >= $past(lim_ph))
		else $error("limit step not honoured");

	cyc_edge_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		!$past(i_cycle_start) |-> $stable(phase_q))
		else $error("phase change off boundary");

	hiz_bound_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(de_state_q == PSEC_HIZ && de_timeout) |=> de_state_q == PSEC_HIGH)
		else $error("diode emulation wait too long");

	thermal_comp_input_off_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		i_thermal_comp_grounded |-> !o_thermal_comp_enable)
		else $error("thermal correction not off");

	// diode emulation steps: wait in high impedance, then fire the high side
	sequence de_fire_s;
		de_state_q == PSEC_HIZ && i_cycle_start;
	endsequence

	sequence de_high_s;
		de_state_q == PSEC_HIGH && o_sw_high && o_sw_oe;
	endsequence

	de_fire_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		de_fire_s |=> de_high_s)
		else $error("diode emulation did not fire");

	sw_excl_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		!(o_sw_high && o_sw_low))
		else $error("both switch sides driven");

	hiz_quiet_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		o_variable_freq_diode_emulation |-> !o_sw_oe && !o_sw_high && !o_sw_low)
		else $error("switch driven while waiting");

	de_single_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		o_variable_freq_diode_emulation |-> phase_q == 2'h1)
		else $error("diode emulation with several phases");

	ph_range_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		phase_q != 2'h0)
		else $error("phase count zero");

	ph_cap_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		i_cycle_start |=> phase_q <= $past(max_ph))
		else $error("phase count above stuffed");

	rearm_wait_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		$rose(armed_q) |-> $past(rearm_cnt_q) == 16'(REARM_DELAY_CYC - 1))
		else $error("shedding re-armed early");

	gd_cfg_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(ps_zero && !ctrl_q[CTRL_GD_HIGH_BIT]) |-> !o_gate_drive_supply_select)
		else $error("gate drive ignores setting");

	gd_mon_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		gd_low_mon |-> !o_gate_drive_supply_select)
		else $error("gate drive high at low monitor");

	shed_off_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(ps_zero && !shed_cfg && i_cycle_start) |=> phase_q == $past(max_ph))
		else $error("shedding while disabled");
endmodule // psec_ctrl

// ===== tb/psec_ps_master.sv
module psec_ps_master (
	input  wire logic       i_sys_clk,
	input  wire logic       i_req,
	input  wire logic [7:0] i_state,
	output logic            o_cmd,
	output logic [7:0]      o_state
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] last_q = 8'h00;
	initial o_cmd = 1'b0;
	initial o_state = 8'hff;
	// state lines only valid with the strobe, otherwise the inverse of the last value
	always @(posedge i_sys_clk) begin
		o_cmd <= i_req;
		o_state <= i_req ? i_state : ~last_q;
		if (i_req) last_q <= i_state;
	end
endmodule // psec_ps_master

// ===== tb/tb.sv
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import psec_pkg::*;
	logic clk = 0, rstn = 0, rd = 0, wr = 0, ps_req = 0, vset = 0, ftr = 0, rg = 0, cyc = 0;
	logic zero_cross_detect = 0, tcg = 0, ps_cmd;
	logic [3:0] adr = 0;
	logic [31:0] wdat = 0, rdat, ev, seed = 32'd79257;
	logic wreq, de, gd, tce, swh, swl, swoe, cyc_l = 0;
	logic [7:0] ps_val = 0, ps_st;
	logic [11:0] mon = 0, lim = 0;
	logic [15:0] ton = 16'h0003, toff = 16'h0004;
	logic [1:0] phc, phc_l = 2'd3;
	logic [4:0] cnt = 0;
	logic [31:0] exp_q[$];
	int miscompares = 0, n_tests = 0, k;
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cnt <= cnt + 5'd1;
		cyc <= (cnt == 5'd0);
	end
	psec_ps_master psec_ps_master_i (.i_sys_clk(clk), .i_req(ps_req), .i_state(ps_val),
		.o_cmd(ps_cmd), .o_state(ps_st));
	psec_ctrl psec_ctrl_i (.i_sys_clk(clk), .i_rstn(rstn), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
		.i_power_state_command(ps_cmd), .i_power_state(ps_st), .i_voltage_set_command(vset),
		.i_fast_transient(ftr), .i_rail_good(rg), .i_shed_strap(1'b1),
		.i_current_monitor(mon), .i_current_limit_voltage(lim), .i_cycle_start(cyc),
		.i_on_time(ton), .i_off_time(toff), .i_zero_cross_detect(zero_cross_detect),
		.i_thermal_comp_grounded(tcg), .o_phase_count(phc),
		.o_variable_freq_diode_emulation(de), .o_gate_drive_supply_select(gd),
		.o_thermal_comp_enable(tce), .o_sw_high(swh), .o_sw_low(swl), .o_sw_oe(swoe));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task end_sim();
		$display("checks %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task settle();
		repeat (2) @(posedge clk);
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wdat <= d;
		do @(posedge clk); while (wreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task cmd(input logic [7:0] v);
		@(posedge clk) ps_req <= 1'b1;
		ps_val <= v;
		@(posedge clk) ps_req <= 1'b0;
		settle();
	endtask
	task gd_loop(input logic [11:0] thr, input logic en);
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			@(posedge clk) mon <= seed[11:0];
			settle();
			`CHK(gd, en & (mon >= thr))
		end
	endtask
	// read data is compared at the edge the slave answers
	always @(posedge clk) begin
		if (rd === 1'b1 && wreq === 1'b0) begin
			ev = exp_q.pop_front();
			`CHK(rdat, ev)
		end
		if (rstn && phc !== phc_l) `CHK(cyc_l, 1'b1)
		phc_l <= phc;
		cyc_l <= cyc;
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(CTRL_OFS, CTRL_RST);
		rd_reg(THR_OFS, {4'h0, THR_23_RST, 4'h0, THR_12_RST});
		rd_reg(GDTHR_OFS, {20'h0, GDTHR_RST});
		bus(1'b1, 4'h2, 32'hffff_ffff);
		rd_reg(4'h2, 32'h0);
		bus(1'b1, CTRL_OFS, 32'h0000_0033);
		rd_reg(CTRL_OFS, 32'h0000_0033);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) tcg <= i[0];
			settle();
			`CHK(tce, !i[0])
		end
		cmd(POWER_STATE_ZERO);
		gd_loop(GDTHR_RST, 1'b1);
		bus(1'b1, GDTHR_OFS, 32'h0000_0800);
		gd_loop(12'h800, 1'b1);
		cmd(POWER_STATE_ONE);
		gd_loop(12'h000, 1'b0);
		@(posedge clk) mon <= 12'h010;
		repeat (100) @(posedge clk);
		`CHK(phc, 2'd2)
		rg <= 1'b1;
		for (k = 0; k < 3000 && phc !== 2'd1; k++) @(posedge clk);
		`CHK(phc, 2'd1)
		lim <= 12'hfff;
		for (k = 0; k < 200 && phc !== 2'd2; k++) @(posedge clk);
		`CHK(phc, 2'd2)
		vset <= 1'b1;
		ftr <= 1'b1;
		@(posedge clk) vset <= 1'b0;
		ftr <= 1'b0;
		lim <= 12'h000;
		repeat (1000) @(posedge clk);
		`CHK(phc, 2'd2)
		for (k = 0; k < 3000 && phc !== 2'd1; k++) @(posedge clk);
		`CHK(phc, 2'd1)
		zero_cross_detect <= 1'b1;
		for (k = 0; k < 100 && swh === 1'b1; k++) @(posedge clk);
		for (k = 0; k < 100 && swh !== 1'b1; k++) @(posedge clk);
		for (k = 0; k < 100 && swh === 1'b1; k++) @(posedge clk);
		`CHK(k[15:0], ton)
		for (k = 0; k < 100 && swl === 1'b1; k++) @(posedge clk);
		`CHK(k[15:0], toff)
		`CHK({swoe, de}, 2'b01)
		end_sim();
	end
endmodule // tb
